// [shared/ssd_pkg.sv]
// constants for the status, diagnostic and auxiliary line block
package ssd_pkg;
	// serial frame and address space
	localparam int ADDR_W = 7;
	localparam logic [4:0] SPI_FRAME_BITS = 5'h10;
	localparam logic [6:0] ADDR_FLASH_CNT = 7'h00;
	localparam logic [6:0] ADDR_ALM1_THR = 7'h26;
	localparam logic [6:0] ADDR_ALM2_THR = 7'h28;
	localparam logic [6:0] ADDR_ALM1_CNT = 7'h2A;
	localparam logic [6:0] ADDR_ALM2_CNT = 7'h2C;
	localparam logic [6:0] ADDR_ALARM_CONTROL = 7'h2E;
	localparam logic [6:0] ADDR_LINE_CFG = 7'h32;
	localparam logic [6:0] ADDR_MISC = 7'h34;
	localparam logic [6:0] ADDR_ERR = 7'h3C;
	// reset values
	localparam logic [15:0] REG_RESET = 16'h0000;
	// writable bit masks
	localparam logic [15:0] MASK_THR = 16'hBFFF;
	localparam logic [15:0] MASK_CNT = 16'h00FF;
	localparam logic [15:0] MASK_ALARM_CONTROL = 16'hFFD7;
	localparam logic [15:0] MASK_LINE_CFG = 16'h0303;
	localparam logic [15:0] MASK_MISC = 16'h07C7;
	// synchroniser bit positions
	localparam int IN_SCLK = 0;
	localparam int IN_CS = 1;
	localparam int IN_MOSI = 2;
	localparam int IN_LINE = 3;
	// digital line config fields
	localparam int LC_DIR = 0;
	localparam int LC_DATA = 8;
	// misc control fields
	localparam int MC_SEL = 0;
	localparam int MC_POL = 1;
	localparam int MC_EN = 2;
	localparam int MC_ALIGN = 6;
	localparam int MC_BIAS = 7;
	localparam int MC_STIM_POS = 8;
	localparam int MC_STIM_NEG = 9;
	localparam int MC_SELFTEST = 10;
	// alarm control fields
	localparam int AC_SEL = 0;
	localparam int AC_POL = 1;
	localparam int AC_EN = 2;
	localparam int AC_FILT = 4;
	localparam int AC_ROC1 = 6;
	localparam int AC_ROC2 = 7;
	localparam int AC_SRC1 = 8;
	localparam int AC_SRC2 = 12;
	// threshold fields
	localparam int THR_GT = 15;
	// error flag fields
	localparam int EF_SUP_LOW = 0;
	localparam int EF_SUP_HIGH = 1;
	localparam int EF_CTRL_FAIL = 2;
	localparam int EF_SPI_FAIL = 3;
	localparam int EF_OVERRANGE = 4;
	localparam int EF_SELFTEST = 5;
	localparam int EF_ALM1 = 8;
	localparam int EF_ALM2 = 9;
	localparam int EF_SENSOR = 10;
	// alarm sources and arithmetic
	localparam int DATA_W = 14;
	localparam int SRC_COUNT = 11;
	localparam logic [3:0] SRC_MAX = 4'hB;
	localparam int SUM_W = 24;
	// flash write counter
	localparam logic [15:0] FLASH_LAST = 16'h7FFF;
	// timing
	localparam int CLK_HZ = 50000000;
	localparam int CLK_PERIOD_NS = 20;
	localparam int SELFTEST_MS = 35;
	localparam int SELFTEST_CYCLES = SELFTEST_MS * (CLK_HZ / 1000);
	localparam int ST_CNT_W = 21;
	localparam int DR_PULSE_NS = 2000;
	localparam int DR_PULSE_CYCLES = (DR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DR_CNT_W = 7;
endpackage : ssd_pkg

// [verilog/ssd_alarm.sv]
// one threshold or rate-of-change alarm channel
`timescale 1ns/1ps
module ssd_alarm #(
	parameter int DATA_W = ssd_pkg::DATA_W,
	parameter int SRC_COUNT = ssd_pkg::SRC_COUNT
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// update strobe
	input wire logic sampleTick,
	// configuration
	input wire logic [3:0] srcSel,
	input wire logic rocEn,
	input wire logic useFilt,
	input wire logic [15:0] threshold,
	input wire logic [7:0] sampleCount,
	// source data
	input wire logic [SRC_COUNT*DATA_W-1:0] srcRaw,
	input wire logic [SRC_COUNT*DATA_W-1:0] srcFilt,
	// result
	output logic active
);
	typedef struct packed {
		logic signed [DATA_W-1:0] prev;
		logic prevValid;
		logic signed [ssd_pkg::SUM_W-1:0] sum;
		logic [7:0] cnt;
		logic active;
	} ssd_alarm_state_t;

	ssd_alarm_state_t st, nxt;
	logic en;
	logic gt;
	int idx;
	logic signed [DATA_W-1:0] val;
	logic signed [DATA_W-1:0] mag;
	logic signed [DATA_W:0] delta;
	logic signed [ssd_pkg::SUM_W-1:0] sumN;
	logic signed [ssd_pkg::SUM_W-1:0] limit;
	logic [7:0] nEff;
	logic [7:0] cntN;

	// evaluation once per update, static or averaged delta
	always_comb begin
		nxt = st;
		en = (srcSel != 4'h0) && (srcSel <= ssd_pkg::SRC_MAX); // R23
		idx = en ? int'(srcSel) - 1 : 0;
		val = useFilt ? srcFilt[idx*DATA_W +: DATA_W] : srcRaw[idx*DATA_W +: DATA_W]; // R18
		mag = threshold[DATA_W-1:0]; // R19 R22
		gt = threshold[ssd_pkg::THR_GT]; // R22
		delta = {val[DATA_W-1], val} - {st.prev[DATA_W-1], st.prev};
		sumN = st.sum + ssd_pkg::SUM_W'(delta);
		// zero samples behaves as one
		nEff = (sampleCount == 8'h00) ? 8'h01 : sampleCount;
		// sum against magnitude times count avoids a divider
		limit = ssd_pkg::SUM_W'(mag) * $signed({1'b0, nEff});
		cntN = st.cnt + 8'h01;
		if (!en) begin
			// disabled channel forgets its history
			nxt = '0;
		end else if (sampleTick) begin
			nxt.prev = val;
			nxt.prevValid = 1'b1;
			if (!rocEn) begin
				nxt.active = gt ? (val > mag) : (val < mag); // R18
				nxt.sum = '0;
				nxt.cnt = 8'h00;
			end else if (st.prevValid) begin
				// window of deltas complete
				if (cntN >= nEff) begin
					nxt.active = gt ? (sumN > limit) : (sumN < limit); // R20
					nxt.sum = '0;
					nxt.cnt = 8'h00;
				end else begin
					nxt.sum = sumN;
					nxt.cnt = cntN;
				end
			end
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= nxt;
		end
	end

	assign active = st.active;

	a_static_cmp: assert property (@(posedge clk) disable iff (rst) (en && sampleTick && !rocEn && gt && val > mag) |=> active) else $error("static alarm missed"); // R18
	a_disabled_idle: assert property (@(posedge clk) disable iff (rst) (srcSel == 4'h0) |=> !active) else $error("disabled alarm active"); // R23
endmodule : ssd_alarm

// [verilog/ssd_status_diag_io.sv]
// status flags, self-test, flash counter, alarms and two auxiliary lines behind the serial port
//
// Contract
// (R01) config bits 0/1 set line direction
// (R02) output lines drive data bit; inputs read pin
// (R03) data-ready beats alarm beats plain line use
// (R04) data-ready enable, polarity and line select
// (R05) writing self-test bit starts test, self-clears
// (R06) self-test lasts 35 ms, data invalid
// (R07) status bit 5 reports self-test failure
// (R08) status bits 10-15 name failing sensors
// (R09) manual stimulus follows bits 9/8, accel positive
// (R10) bits 7/6 enable bias and alignment
// (R11) flash write counter increments and wraps
// (R12) supply and overrange flags clear automatically
// (R13) other flags sticky; status read clears all
// (R14) lasting condition sets flag next update
// (R15) bit 3 serial failure, bit 2 update failure
// (R16) bit 0 supply low, bit 1 high
// (R17) status bits 9/8 show alarm states
// (R18) two alarms compare selected data to threshold
// (R19) threshold holds magnitude plus direction bit
// (R20) rate mode averages deltas over sample count
// (R21) alarm control selects source, mode, filter, line
// (R22) threshold bit 15 direction, 13:0 data
// (R23) four-bit source select, zero disables
// (R24) bits 7/6 rate mode, bit 4 filtered
// (R25) alarm output enable, polarity, line select
// (R26) alarms evaluated each update, drive line
// (R27) data-ready pulse lasts fixed cycles
`timescale 1ns/1ps
module ssd_status_diag_io #(
	parameter int SELFTEST_CYCLES = ssd_pkg::SELFTEST_CYCLES,
	parameter int DATA_W = ssd_pkg::DATA_W,
	parameter int SRC_COUNT = ssd_pkg::SRC_COUNT
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// serial port pins
	input wire logic sclk,
	input wire logic csN,
	input wire logic mosi,
	output logic miso,
	output logic misoOeN,
	// auxiliary lines, two-way
	input wire logic [1:0] lineIn,
	output logic [1:0] lineOut,
	output logic [1:0] lineOeN,
	// internal update and events
	input wire logic sampleTick,
	input wire logic flashWritePulse,
	input wire logic ctrlUpdateFail,
	input wire logic supplyLow,
	input wire logic supplyHigh,
	input wire logic overrange,
	input wire logic [5:0] selfTestFail,
	// alarm source data
	input wire logic [SRC_COUNT*DATA_W-1:0] srcRaw,
	input wire logic [SRC_COUNT*DATA_W-1:0] srcFilt,
	// sensor controls
	output logic dataValid,
	output logic selfTestActive,
	output logic stimPosGyro,
	output logic stimNegGyro,
	output logic stimPosAccel,
	output logic gyroBiasCompEn,
	output logic accelAlignEn
);
	typedef struct packed {
		logic [4:0] syncA;
		logic [4:0] syncB;
		logic [4:0] syncC;
		logic [4:0] filt;
		logic sclkPrev;
		logic csPrev;
		logic [4:0] bitCnt;
		logic [15:0] shiftIn;
		logic [15:0] shiftOut;
		logic [6:0] readAddr;
		logic miso;
		logic misoOeN;
		logic [15:0] thr1;
		logic [15:0] thr2;
		logic [15:0] smp1;
		logic [15:0] smp2;
		logic [15:0] almCtrl;
		logic [15:0] lineCfg;
		logic [15:0] misc;
		logic [15:0] flashCnt;
		logic [15:0] errFlags;
		logic stRun;
		logic [ssd_pkg::ST_CNT_W-1:0] stCnt;
		logic drActive;
		logic [ssd_pkg::DR_CNT_W-1:0] drCnt;
		logic [1:0] lineOut;
		logic [1:0] lineOeN;
		logic dataValid;
		logic stimPosGyro;
		logic stimNegGyro;
		logic stimPosAccel;
		logic biasComp;
		logic accelAlign;
	} ssd_state_t;

	ssd_state_t st, nxt;
	logic alm1, alm2;          // alarm channel results
	logic almAny;              // either alarm holding
	logic sclkRise;            // filtered serial clock rising edge
	logic csFall, csRise;      // frame boundaries
	logic [15:0] rdWord;       // read mux output
	logic [15:0] lineRead;     // line config as read back
	logic [6:0] wrWord;        // even address of a written byte
	logic wrHi;                // high byte written
	logic [7:0] wrByte;        // written byte
	logic doWrite;             // well-formed write frame ends
	logic clearErr;            // status word taken by a read
	logic drClaim, almClaim;   // per-line claims in the loop

	// byte write into a word, unused bits held at zero
	function automatic logic [15:0] ssd_put_byte(input logic [15:0] old, input logic [7:0] b,
		input logic hi, input logic [15:0] mask);
		logic [15:0] w;
		w = hi ? {b, old[7:0]} : {old[15:8], b};
		return w & mask;
	endfunction : ssd_put_byte

	// two alarm channels share the source buses
	ssd_alarm #(.DATA_W(DATA_W), .SRC_COUNT(SRC_COUNT)) u_alarm1 (
		.clk(clk), .rst(rst), .sampleTick(sampleTick),
		.srcSel(st.almCtrl[ssd_pkg::AC_SRC1 +: 4]), .rocEn(st.almCtrl[ssd_pkg::AC_ROC1]), // R24
		.useFilt(st.almCtrl[ssd_pkg::AC_FILT]), .threshold(st.thr1), .sampleCount(st.smp1[7:0]), // R24
		.srcRaw(srcRaw), .srcFilt(srcFilt), .active(alm1)
	);
	ssd_alarm #(.DATA_W(DATA_W), .SRC_COUNT(SRC_COUNT)) u_alarm2 (
		.clk(clk), .rst(rst), .sampleTick(sampleTick),
		.srcSel(st.almCtrl[ssd_pkg::AC_SRC2 +: 4]), .rocEn(st.almCtrl[ssd_pkg::AC_ROC2]), // R24
		.useFilt(st.almCtrl[ssd_pkg::AC_FILT]), .threshold(st.thr2), .sampleCount(st.smp2[7:0]),
		.srcRaw(srcRaw), .srcFilt(srcFilt), .active(alm2)
	);

	// readback and the frame decode
	always_comb begin
		almAny = alm1 | alm2;
		sclkRise = st.filt[ssd_pkg::IN_SCLK] & ~st.sclkPrev;
		csFall = st.csPrev & ~st.filt[ssd_pkg::IN_CS];
		csRise = ~st.csPrev & st.filt[ssd_pkg::IN_CS];
		// data bits read the pin when the line is an input
		lineRead = st.lineCfg;
		for (int i = 0; i < 2; i++) begin
			lineRead[ssd_pkg::LC_DATA+i] = st.lineCfg[ssd_pkg::LC_DIR+i] ?
				st.lineCfg[ssd_pkg::LC_DATA+i] : st.filt[ssd_pkg::IN_LINE+i]; // R02
		end
		// word read mux, unmapped addresses read zero
		unique case ({st.readAddr[6:1], 1'b0})
			ssd_pkg::ADDR_FLASH_CNT: rdWord = st.flashCnt;
			ssd_pkg::ADDR_ALM1_THR: rdWord = st.thr1;
			ssd_pkg::ADDR_ALM2_THR: rdWord = st.thr2;
			ssd_pkg::ADDR_ALM1_CNT: rdWord = st.smp1;
			ssd_pkg::ADDR_ALM2_CNT: rdWord = st.smp2;
			ssd_pkg::ADDR_ALARM_CONTROL: rdWord = st.almCtrl;
			ssd_pkg::ADDR_LINE_CFG: rdWord = lineRead;
			ssd_pkg::ADDR_MISC: begin
				rdWord = st.misc;
				rdWord[ssd_pkg::MC_SELFTEST] = st.stRun; // R05
			end
			ssd_pkg::ADDR_ERR: rdWord = st.errFlags;
			default: rdWord = 16'h0000;
		endcase
		wrWord = {st.shiftIn[14:9], 1'b0};
		wrHi = st.shiftIn[8];
		wrByte = st.shiftIn[7:0];
		doWrite = csRise && (st.bitCnt == ssd_pkg::SPI_FRAME_BITS) && st.shiftIn[15];
		// the read that loads the status word clears it
		clearErr = csFall && ({st.readAddr[6:1], 1'b0} == ssd_pkg::ADDR_ERR); // R13
	end

	// next state of the whole block
	always_comb begin
		nxt = st;
		drClaim = 1'b0;
		almClaim = 1'b0;
		// three-stage pin sampling, value moves when stages two and three agree
		nxt.syncA = {lineIn, mosi, csN, sclk};
		nxt.syncB = st.syncA;
		nxt.syncC = st.syncB;
		nxt.filt = (~(st.syncB ^ st.syncC) & st.syncC) | ((st.syncB ^ st.syncC) & st.filt);
		nxt.sclkPrev = st.filt[ssd_pkg::IN_SCLK];
		nxt.csPrev = st.filt[ssd_pkg::IN_CS];
		// serial frame: mode 3, sample on rise; the pin sync delay is longer than a
		// short low phase, so each bit goes out just after the rise that took the last
		if (csFall) begin
			nxt.bitCnt = 5'h00;
			nxt.shiftOut = rdWord;
			nxt.miso = rdWord[15];
			nxt.misoOeN = 1'b0;
		end else if (!st.filt[ssd_pkg::IN_CS]) begin
			if (sclkRise) begin
				nxt.shiftIn = {st.shiftIn[14:0], st.filt[ssd_pkg::IN_MOSI]};
				if (st.bitCnt != 5'h1F) begin
					nxt.bitCnt = st.bitCnt + 5'h01;
				end
				// stable for the whole next clock period on the host side
				nxt.shiftOut = {st.shiftOut[14:0], 1'b0};
				nxt.miso = st.shiftOut[14];
			end
		end
		if (csRise) begin
			nxt.misoOeN = 1'b1;
			// a read frame names the word returned in the next frame
			if (st.bitCnt == ssd_pkg::SPI_FRAME_BITS && !st.shiftIn[15]) begin
				nxt.readAddr = st.shiftIn[14:8];
			end
		end
		// register writes, one byte per frame
		if (doWrite) begin
			unique case (wrWord)
				ssd_pkg::ADDR_ALM1_THR: nxt.thr1 = ssd_put_byte(st.thr1, wrByte, wrHi, ssd_pkg::MASK_THR); // R19
				ssd_pkg::ADDR_ALM2_THR: nxt.thr2 = ssd_put_byte(st.thr2, wrByte, wrHi, ssd_pkg::MASK_THR); // R19
				ssd_pkg::ADDR_ALM1_CNT: nxt.smp1 = ssd_put_byte(st.smp1, wrByte, wrHi, ssd_pkg::MASK_CNT);
				ssd_pkg::ADDR_ALM2_CNT: nxt.smp2 = ssd_put_byte(st.smp2, wrByte, wrHi, ssd_pkg::MASK_CNT);
				ssd_pkg::ADDR_ALARM_CONTROL: nxt.almCtrl = ssd_put_byte(st.almCtrl, wrByte, wrHi, ssd_pkg::MASK_ALARM_CONTROL); // R21
				ssd_pkg::ADDR_LINE_CFG: nxt.lineCfg = ssd_put_byte(st.lineCfg, wrByte, wrHi, ssd_pkg::MASK_LINE_CFG);
				ssd_pkg::ADDR_MISC: nxt.misc = ssd_put_byte(st.misc, wrByte, wrHi, ssd_pkg::MASK_MISC);
				default: nxt.misc = nxt.misc;
			endcase
		end
		// self-test start; a write while running cannot restart it
		if (doWrite && wrWord == ssd_pkg::ADDR_MISC && wrHi && wrByte[ssd_pkg::MC_SELFTEST-8] && !st.stRun) begin
			nxt.stRun = 1'b1; // R05
			nxt.stCnt = ssd_pkg::ST_CNT_W'(SELFTEST_CYCLES - 1); // R06
		end else if (st.stRun) begin
			if (st.stCnt == '0) begin
				nxt.stRun = 1'b0; // R05
			end else begin
				nxt.stCnt = st.stCnt - 1'b1;
			end
		end
		nxt.misc[ssd_pkg::MC_SELFTEST] = 1'b0;
		nxt.dataValid = ~nxt.stRun; // R06
		// static controls follow their bits directly
		nxt.stimPosGyro = nxt.misc[ssd_pkg::MC_STIM_POS]; // R09
		nxt.stimNegGyro = nxt.misc[ssd_pkg::MC_STIM_NEG]; // R09
		nxt.stimPosAccel = nxt.misc[ssd_pkg::MC_STIM_POS]; // R09
		nxt.biasComp = nxt.misc[ssd_pkg::MC_BIAS]; // R10
		nxt.accelAlign = nxt.misc[ssd_pkg::MC_ALIGN]; // R10
		// flash write counter wraps after its last count
		if (flashWritePulse) begin
			nxt.flashCnt = (st.flashCnt == ssd_pkg::FLASH_LAST) ? 16'h0000 : st.flashCnt + 16'h0001; // R11
		end
		// data-ready pulse after each update, none while testing
		if (sampleTick && !st.stRun) begin
			nxt.drActive = 1'b1; // R27
			nxt.drCnt = ssd_pkg::DR_CNT_W'(ssd_pkg::DR_PULSE_CYCLES - 1); // R27
		end else if (st.drActive) begin
			if (st.drCnt == '0) begin
				nxt.drActive = 1'b0;
			end else begin
				nxt.drCnt = st.drCnt - 1'b1;
			end
		end
		// status flags: clear by read first, sets afterwards so a set wins
		if (clearErr) begin
			nxt.errFlags = 16'h0000; // R13
		end
		// supply and overrange bits drop with their condition
		if (!supplyLow) nxt.errFlags[ssd_pkg::EF_SUP_LOW] = 1'b0; // R12
		if (!supplyHigh) nxt.errFlags[ssd_pkg::EF_SUP_HIGH] = 1'b0; // R12
		if (!overrange) nxt.errFlags[ssd_pkg::EF_OVERRANGE] = 1'b0; // R12
		// conditions are taken at each update, so a lasting one returns
		if (sampleTick) begin
			if (supplyLow) nxt.errFlags[ssd_pkg::EF_SUP_LOW] = 1'b1; // R16 R14
			if (supplyHigh) nxt.errFlags[ssd_pkg::EF_SUP_HIGH] = 1'b1; // R16 R14
			if (overrange) nxt.errFlags[ssd_pkg::EF_OVERRANGE] = 1'b1; // R14
			if (alm1) nxt.errFlags[ssd_pkg::EF_ALM1] = 1'b1; // R17 R26
			if (alm2) nxt.errFlags[ssd_pkg::EF_ALM2] = 1'b1; // R17 R26
		end
		if (ctrlUpdateFail) nxt.errFlags[ssd_pkg::EF_CTRL_FAIL] = 1'b1; // R15
		// a frame with the wrong bit count is a serial failure
		if (csRise && st.bitCnt != ssd_pkg::SPI_FRAME_BITS) begin
			nxt.errFlags[ssd_pkg::EF_SPI_FAIL] = 1'b1; // R15
		end
		// self-test outcome captured as the test ends
		if (st.stRun && st.stCnt == '0 && selfTestFail != 6'h00) begin
			nxt.errFlags[ssd_pkg::EF_SELFTEST] = 1'b1; // R07
			nxt.errFlags[ssd_pkg::EF_SENSOR +: 6] = selfTestFail; // R08
		end
		// line ownership: data-ready, then alarm, then plain use
		for (int i = 0; i < 2; i++) begin
			drClaim = st.misc[ssd_pkg::MC_EN] && (st.misc[ssd_pkg::MC_SEL] == i[0]); // R04
			almClaim = st.almCtrl[ssd_pkg::AC_EN] && (st.almCtrl[ssd_pkg::AC_SEL] == i[0]); // R25
			if (drClaim) begin
				nxt.lineOeN[i] = 1'b0; // R03
				nxt.lineOut[i] = st.drActive ~^ st.misc[ssd_pkg::MC_POL]; // R04
			end else if (almClaim) begin
				nxt.lineOeN[i] = 1'b0; // R03
				nxt.lineOut[i] = almAny ~^ st.almCtrl[ssd_pkg::AC_POL]; // R25 R26
			end else if (st.lineCfg[ssd_pkg::LC_DIR+i]) begin
				nxt.lineOeN[i] = 1'b0; // R01
				nxt.lineOut[i] = st.lineCfg[ssd_pkg::LC_DATA+i]; // R02
			end else begin
				nxt.lineOeN[i] = 1'b1; // R01
				nxt.lineOut[i] = 1'b0;
			end
		end
	end

	// state register; idle pins read high so no false frame at release
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
			st.syncA <= 5'h03;
			st.syncB <= 5'h03;
			st.syncC <= 5'h03;
			st.filt <= 5'h03;
			st.sclkPrev <= 1'b1;
			st.csPrev <= 1'b1;
			st.misoOeN <= 1'b1;
			st.lineOeN <= 2'h3;
			st.dataValid <= 1'b1;
		end else begin
			st <= nxt;
		end
	end

	// outputs straight from the state register
	assign miso = st.miso;
	assign misoOeN = st.misoOeN;
	assign lineOut = st.lineOut;
	assign lineOeN = st.lineOeN;
	assign dataValid = st.dataValid;
	assign selfTestActive = st.stRun;
	assign stimPosGyro = st.stimPosGyro;
	assign stimNegGyro = st.stimNegGyro;
	assign stimPosAccel = st.stimPosAccel;
	assign gyroBiasCompEn = st.biasComp;
	assign accelAlignEn = st.accelAlign;

	a_dr_priority: assert property (@(posedge clk) disable iff (rst) (st.misc[2:0] == 3'h6 && st.lineCfg[0] == 1'b0) |=> !lineOeN[0] && lineOut[0] == $past(st.drActive)) else $error("data-ready lost line one"); // R03
	a_line_input: assert property (@(posedge clk) disable iff (rst) (!st.misc[2] && !st.almCtrl[2] && !st.lineCfg[1]) |=> lineOeN[1]) else $error("input line driven"); // R01
	a_st_length: assert property (@(posedge clk) disable iff (rst) $rose(st.stRun) |-> (st.stCnt == ssd_pkg::ST_CNT_W'(SELFTEST_CYCLES - 1)) && !dataValid) else $error("self-test length wrong"); // R06
	a_st_hold: assert property (@(posedge clk) disable iff (rst) (st.stRun && st.stCnt != '0) |=> st.stRun && !dataValid) else $error("self-test ended early"); // R05
	a_flash_wrap: assert property (@(posedge clk) disable iff (rst) (flashWritePulse && st.flashCnt == ssd_pkg::FLASH_LAST) |=> st.flashCnt == 16'h0000) else $error("flash counter did not wrap"); // R11
	a_flash_inc: assert property (@(posedge clk) disable iff (rst) (flashWritePulse && st.flashCnt != ssd_pkg::FLASH_LAST) |=> st.flashCnt == $past(st.flashCnt) + 16'h0001) else $error("flash counter missed a write"); // R11
	a_sup_auto: assert property (@(posedge clk) disable iff (rst) !supplyLow |=> !st.errFlags[ssd_pkg::EF_SUP_LOW]) else $error("supply flag stuck"); // R12
	a_read_clear: assert property (@(posedge clk) disable iff (rst) (clearErr && !sampleTick && !ctrlUpdateFail && !st.stRun && !csRise) |=> st.errFlags == 16'h0000) else $error("status read did not clear"); // R13
	a_alarm_flag: assert property (@(posedge clk) disable iff (rst) (sampleTick && alm1) |=> st.errFlags[ssd_pkg::EF_ALM1]) else $error("alarm one flag missed"); // R17
	a_dr_pulse: assert property (@(posedge clk) disable iff (rst) (sampleTick && !st.stRun) |=> st.drActive[*8]) else $error("data-ready pulse too short"); // R27
endmodule : ssd_status_diag_io

// [verification/ssd_host_model.sv]
// serial host model: mode 3 frames, MSB first, data changed on falling sclk
`timescale 1ns/1ps
module ssd_host_model (
	// serial pins
	output logic sclk,
	output logic csN,
	output logic mosi,
	input wire logic miso,
	input wire logic misoOeN
);
	int halfNs = 80; // 160 ns serial clock period
	// pins idle: clock high, select off
	initial begin
		sclk = 1'h1;
		csN = 1'h1;
		mosi = 1'h0;
	end
	// one frame of n bits; rx gathers miso at each rising sclk
	task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx);
		rx = 16'h0000;
		csN = 1'h0;
		for (int i = 15; i > 15 - n; i--) begin
			#(halfNs) sclk = 1'h0;
			mosi = tx[i];
			#(halfNs) sclk = 1'h1;
			rx = {rx[14:0], misoOeN ? 1'hx : miso};
		end
		#(halfNs) csN = 1'h1;
		mosi = ~mosi; // released line shows no stale level
		#(halfNs * 2);
	endtask : frame
endmodule : ssd_host_model

// [verification/test_ssd_status_diag_io.sv]
// self-checking bench for the status, diagnostic and auxiliary line block
`timescale 1ns/1ps
module test_ssd_status_diag_io;
	logic clk = 1'h0, rst = 1'h1, sampleTick = 1'h0, flashWritePulse = 1'h0, ctrlUpdateFail = 1'h0;
	logic supplyLow = 1'h0, supplyHigh = 1'h0, overrange = 1'h0;
	logic [5:0] selfTestFail = 6'h00;
	logic [1:0] ext = 2'h0, lineIn, lineOut, lineOeN;
	logic [ssd_pkg::SRC_COUNT*ssd_pkg::DATA_W-1:0] srcRaw = '0, srcFilt = '0;
	logic sclk, csN, mosi, miso, misoOeN, dataValid, selfTestActive;
	logic stimPosGyro, stimNegGyro, stimPosAccel, gyroBiasCompEn, accelAlignEn;
	logic [15:0] pins, resVal, rx, expQ[$];
	string nameQ[$];
	event resEv;
	int fails = 0, check_count = 0, n;
	localparam logic [6:0] MISC = ssd_pkg::ADDR_MISC, ERR = ssd_pkg::ADDR_ERR;
	// pin level: a driving line shows its output, else the outside level
	assign lineIn = (lineOeN & ext) | (~lineOeN & lineOut);
	// snapshot of the side outputs; undriven line outputs masked off
	assign pins = {3'h0, stimPosGyro, stimNegGyro, stimPosAccel, gyroBiasCompEn, accelAlignEn,
		2'h0, dataValid, selfTestActive, lineOeN, lineOut & ~lineOeN};
	ssd_status_diag_io #(.SELFTEST_CYCLES(2000)) i_dut (
		.clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso), .misoOeN(misoOeN),
		.lineIn(lineIn), .lineOut(lineOut), .lineOeN(lineOeN), .sampleTick(sampleTick),
		.flashWritePulse(flashWritePulse), .ctrlUpdateFail(ctrlUpdateFail), .supplyLow(supplyLow),
		.supplyHigh(supplyHigh), .overrange(overrange), .selfTestFail(selfTestFail), .srcRaw(srcRaw),
		.srcFilt(srcFilt), .dataValid(dataValid), .selfTestActive(selfTestActive), .stimPosGyro(stimPosGyro),
		.stimNegGyro(stimNegGyro), .stimPosAccel(stimPosAccel), .gyroBiasCompEn(gyroBiasCompEn),
		.accelAlignEn(accelAlignEn)
	);
	ssd_host_model i_host (.sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso), .misoOeN(misoOeN));
	initial forever #10 clk = ~clk;
	task automatic compareWord(input string name, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : compareWord
	// watcher: every result is paired with the oldest note
	initial forever begin
		@(resEv);
		compareWord(nameQ.pop_front(), expQ.pop_front(), resVal);
	end
	task automatic note(input string name, input logic [15:0] exp, input logic [15:0] got);
		nameQ.push_back(name);
		expQ.push_back(exp);
		resVal = got;
		->resEv;
		@(negedge clk);
	endtask : note
	task automatic w(input int k);
		repeat (k) @(negedge clk);
	endtask : w
	task automatic pulse(ref logic s, input int k);
		repeat (k) begin
			@(negedge clk) s = 1'h1;
			@(negedge clk) s = 1'h0;
		end
	endtask : pulse
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		i_host.frame({1'h1, a, d}, 16, rx);
	endtask : wr
	// read answer arrives in the following frame
	task automatic rd(input string name, input logic [6:0] a, input logic [15:0] exp);
		i_host.frame({1'h0, a, 8'h00}, 16, rx);
		i_host.frame(16'h0000, 16, rx);
		note(name, exp, rx);
	endtask : rd
	task automatic final_report();
		if (fails == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report
	// watchdog, well past the expected run
	initial begin
		#1000000;
		fails++;
		final_report();
	end
	initial begin
		n = $urandom(2189);
		w(5);
		rst = 1'h0;
		w(8);
		note("pins", 16'h002C, pins);
		rd("flash", ssd_pkg::ADDR_FLASH_CNT, 16'h0000);
		rd("linecfg", ssd_pkg::ADDR_LINE_CFG, 16'h0000);
		rd("misc", MISC, 16'h0000);
		rd("status", ERR, 16'h0000);
		rd("unmapped", 7'h10, 16'h0000);
		// line two output high, line one input at a random level
		ext = 2'($urandom);
		wr(ssd_pkg::ADDR_LINE_CFG + 7'h01, 8'h02);
		wr(ssd_pkg::ADDR_LINE_CFG, 8'h02);
		w(10);
		note("pins", 16'h0026, pins);
		rd("linecfg", ssd_pkg::ADDR_LINE_CFG, {6'h00, 1'h1, ext[0], 8'h02});
		// data-ready on line one, active high, overriding the input setting
		wr(MISC, 8'h06);
		w(10);
		pulse(sampleTick, 1);
		w(4);
		note("pins", 16'h0023, pins);
		w(100);
		note("pins", 16'h0022, pins);
		wr(MISC + 7'h01, 8'h03);
		wr(MISC, 8'hC6);
		w(10);
		note("pins", 16'h1F22, pins);
		wr(MISC + 7'h01, 8'h01);
		w(10);
		note("pins", 16'h1722, pins);
		// self-test with a random set of failing sensors
		selfTestFail = 6'($urandom) | 6'h01;
		wr(MISC + 7'h01, 8'h04);
		w(10);
		note("pins", 16'h0312, pins);
		rd("misc", MISC, 16'h04C6);
		w(2000);
		note("pins", 16'h0322, pins);
		rd("misc", MISC, 16'h00C6);
		rd("status", ERR, {selfTestFail, 10'h020});
		rd("status", ERR, 16'h0000);
		selfTestFail = 6'h00;
		// supply, overrange, update and serial faults
		supplyLow = 1'h1;
		overrange = 1'h1;
		pulse(ctrlUpdateFail, 1);
		i_host.frame(16'hFF00, 8, rx);
		pulse(sampleTick, 1);
		w(5);
		rd("status", ERR, 16'h001D);
		supplyLow = 1'h0;
		overrange = 1'h0;
		supplyHigh = 1'h1;
		pulse(ctrlUpdateFail, 1);
		pulse(sampleTick, 1);
		w(5);
		rd("status", ERR, 16'h0006);
		pulse(sampleTick, 1);
		w(5);
		rd("status", ERR, 16'h0002);
		supplyHigh = 1'h0;
		pulse(sampleTick, 1);
		n = $urandom_range(9, 3);
		pulse(flashWritePulse, n);
		rd("flash", ssd_pkg::ADDR_FLASH_CNT, 16'(n));
		// alarm one: raw source 1 above 100, line two active high
		wr(ssd_pkg::ADDR_ALM1_THR + 7'h01, 8'h80);
		wr(ssd_pkg::ADDR_ALM1_THR, 8'h64);
		srcRaw[13:0] = 14'(100 + $urandom_range(500, 1));
		wr(ssd_pkg::ADDR_LINE_CFG + 7'h01, 8'h00);
		wr(ssd_pkg::ADDR_ALARM_CONTROL + 7'h01, 8'h01);
		wr(ssd_pkg::ADDR_ALARM_CONTROL, 8'h07);
		pulse(sampleTick, 1);
		w(4);
		note("pins", 16'h0323, pins);
		pulse(sampleTick, 1);
		w(4);
		rd("status", ERR, 16'h0100);
		srcRaw[13:0] = 14'h0000;
		pulse(sampleTick, 1);
		w(110);
		note("pins", 16'h0320, pins);
		wr(ssd_pkg::ADDR_ALM1_THR + 7'h01, 8'h00);
		pulse(sampleTick, 1);
		w(4);
		note("pins", 16'h0323, pins);
		// filtered data: raw zero would trip less-than 100, filtered 200 does not
		srcFilt[13:0] = 14'h00C8;
		wr(ssd_pkg::ADDR_ALARM_CONTROL, 8'h17);
		pulse(sampleTick, 1);
		w(4);
		note("pins", 16'h0321, pins);
		// rate mode, greater than 100: first level -300 stays quiet, a step of 250 to -50 trips
		wr(ssd_pkg::ADDR_ALARM_CONTROL, 8'h47);
		wr(ssd_pkg::ADDR_ALM1_THR + 7'h01, 8'h80);
		srcRaw[13:0] = 14'h3ED4;
		pulse(sampleTick, 1);
		srcRaw[13:0] = 14'h3FCE;
		pulse(sampleTick, 1);
		w(4);
		note("pins", 16'h0323, pins);
		final_report();
	end
endmodule : test_ssd_status_diag_io
